// [hdl/dfs_pkg.sv]
// Constants, types and fault codes shared by the drive fault supervisor.
// Assumes a single 10 MHz system clock and comparator-style status inputs.
package dfs_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;

    // Sustained-load timing figures in their printed units.
    localparam int unsigned MOTOR_OL_TIME_S = 60;
    localparam int unsigned DRV_OL110_TIME_S = 60;
    localparam int unsigned DRV_OL130_TIME_S = 4;

    localparam longint unsigned MOTOR_OL_CYC = MOTOR_OL_TIME_S * CLK_HZ;
    localparam longint unsigned DRV_OL110_CYC = DRV_OL110_TIME_S * CLK_HZ;
    localparam longint unsigned DRV_OL130_CYC = DRV_OL130_TIME_S * CLK_HZ;

    localparam int unsigned CNT_W = 30;
    localparam int unsigned HIST_DEPTH = 5;
    localparam int unsigned HIST_IDX_W = 3;
    localparam int unsigned STAT_W = 16;
    localparam int unsigned CODE_W = 4;

    // Register map, one word index each; byte address is four times it.
    localparam logic [3:0] ADDR_ACTIVE = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;
    localparam logic [3:0] ADDR_HIST0 = 4'h4;

    localparam int unsigned CTRL_RESET_BIT = 0;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_TRIP_BIT = 0;
    localparam int unsigned IRQ_COM_BIT = 1;

    typedef enum logic [CODE_W-1:0] {
        DFS_F_NONE   = 4'h0,
        DFS_F_OC1    = 4'h1,
        DFS_F_GND    = 4'h2,
        DFS_F_OV     = 4'h3,
        DFS_F_OL     = 4'h4,
        DFS_F_OH     = 4'h5,
        DFS_F_ETH    = 4'h6,
        DFS_F_EXT    = 4'h7,
        DFS_F_LV     = 4'h8,
        DFS_F_OC2    = 4'h9,
        DFS_F_PHO    = 4'hA,
        DFS_F_HWD    = 4'hB,
        DFS_F_COM    = 4'hC,
        DFS_F_IOLT   = 4'hD,
        DFS_F_NTC    = 4'hE
    } dfs_code_e;

    typedef enum logic [1:0] {
        DFS_RUN  = 2'b00,
        DFS_TRIP = 2'b01
    } dfs_state_e;

    // Comparator and status indications from the sensing front end.
    typedef struct packed {
        logic over200;
        logic over130;
        logic over120;
        logic over110;
        logic gndFault;
        logic busOver;
        logic busUnder;
        logic heatSinkHot;
        logic shortThrough;
        logic phaseOpen;
        logic extTrip;
        logic wdogErr;
        logic nvmErr;
        logic inPhaseOpen;
        logic tempSenseOpen;
        logic adcOffsetErr;
        logic keypadLost;
    } dfs_sense_s;

    typedef struct packed {
        dfs_code_e              code;
        logic [STAT_W-1:0]      status;
    } dfs_hist_s;

endpackage

// [hdl/dfs_supervisor.sv]
// Drive fault supervisor: trip detection, fault latch, history and regs.
// Assumes sensing inputs are asynchronous pins and the register master
// sits on clk_sys.
// Function
// - Any fault blocks power output at once and shows the active fault code.
// - Keep last five faults with operating status, oldest displaced first.
// - Trip first overcurrent when output current exceeds 200 percent rated.
// - Trip ground fault when sensed ground current exceeds internal threshold.
// - Trip overvoltage when DC bus rises above rated value.
// - Trip current-limit overload when current flows at 120 percent rated.
// - Trip overheat when heat sink over-temperature indication is active.
// - Trip motor thermal after 130 percent load sustained one minute; the four-second drive overload on the same load trips first.
// - Closed normally open external trip contact blocks output and records fault.
// - Trip undervoltage when DC bus falls below detection level.
// - Trip second overcurrent on shoot-through or output short.
// - Trip output phase open when any output phase is open.
// - Instant cutoff blocks output while asserted, resumes without reset.
// - Hardware diagnostic fault on any control circuitry error; thermistor open reports the thermistor fault instead.
// - Flag communication error on keypad communication loss.
// - Drive overload after 110 percent one minute or 130 percent four seconds.
// - Display thermistor open fault when sensing element opens.
// - Keypad reset, reset terminal or power cycle clears a latched fault.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dfs_supervisor #(
    parameter longint unsigned MotorOlCyc  = dfs_pkg::MOTOR_OL_CYC,
    parameter longint unsigned DrvOl110Cyc = dfs_pkg::DRV_OL110_CYC,
    parameter longint unsigned DrvOl130Cyc = dfs_pkg::DRV_OL130_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire dfs_pkg::dfs_sense_s        senseIn,
    input  wire logic                       instant_cutoff_input,
    input  wire logic                       fault_reset_terminal,
    input  wire logic [dfs_pkg::STAT_W-1:0] opStatus,
    input  wire logic [3:0]                 regAddr,
    input  wire logic [31:0]                regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic [31:0]                     regRdata,
    output logic                            gateEnable,
    output logic [dfs_pkg::CODE_W-1:0]      active_fault_view,
    output logic                            hardware_diag_fault,
    output logic                            drive_overload_trip,
    output logic                            irqOut
);
    import dfs_pkg::*;

    localparam int unsigned SYNC_W = $bits(dfs_sense_s) + 2;

    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    dfs_sense_s        sense;
    logic              cutoff;
    logic              resetPin;
    logic              resetPinD_q;

    // Two-stage synchronisers; only syncB feeds logic.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {senseIn, instant_cutoff_input, fault_reset_terminal};
            syncB_q <= syncA_q;
        end
    end
    assign sense    = dfs_sense_s'(syncB_q[SYNC_W-1:2]);
    assign cutoff   = syncB_q[1];
    assign resetPin = syncB_q[0];

    // Sustained-load timers.
    logic [CNT_W-1:0] ethCnt_q;
    logic [CNT_W-1:0] ol110Cnt_q;
    logic [CNT_W-1:0] ol130Cnt_q;
    logic             ethDone;
    logic             ol110Done;
    logic             ol130Done;

    assign ethDone   = (ethCnt_q == CNT_W'(MotorOlCyc - 1));
    assign ol110Done = (ol110Cnt_q == CNT_W'(DrvOl110Cyc - 1));
    assign ol130Done = (ol130Cnt_q == CNT_W'(DrvOl130Cyc - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ethCnt_q   <= '0;
            ol110Cnt_q <= '0;
            ol130Cnt_q <= '0;
        end else begin
            // A simple integrator; cooling is modelled as an instant reset.
            ethCnt_q <= !sense.over130 ? '0 :
                        ethDone ? ethCnt_q : ethCnt_q + 1'b1;
            ol110Cnt_q <= !sense.over110 ? '0 :
                          ol110Done ? ol110Cnt_q : ol110Cnt_q + 1'b1;
            ol130Cnt_q <= !sense.over130 ? '0 :
                          ol130Done ? ol130Cnt_q : ol130Cnt_q + 1'b1;
        end
    end

    // Fault priority: earlier in the list wins only when coincident.
    logic      hwErr;
    dfs_code_e detCode;
    assign hwErr = sense.wdogErr | sense.nvmErr | sense.inPhaseOpen |
                   sense.tempSenseOpen | sense.adcOffsetErr;

    always_comb begin
        detCode = DFS_F_NONE;
        if (sense.shortThrough) detCode = DFS_F_OC2;
        else if (sense.over200) detCode = DFS_F_OC1;
        else if (sense.gndFault) detCode = DFS_F_GND;
        else if (sense.busOver) detCode = DFS_F_OV;
        else if (sense.busUnder) detCode = DFS_F_LV;
        else if (sense.tempSenseOpen) detCode = DFS_F_NTC;
        else if (hwErr) detCode = DFS_F_HWD;
        else if (sense.heatSinkHot) detCode = DFS_F_OH;
        else if (sense.phaseOpen) detCode = DFS_F_PHO;
        else if (sense.extTrip) detCode = DFS_F_EXT;
        else if (ol110Done || ol130Done) detCode = DFS_F_IOLT;
        else if (ethDone) detCode = DFS_F_ETH;
        else if (sense.over120) detCode = DFS_F_OL;
        else if (sense.keypadLost) detCode = DFS_F_COM;
    end

    // Fault latch.
    dfs_state_e state_q;
    dfs_code_e  code_q;
    logic       swReset;
    logic       resetEv;
    logic       tripEv;

    assign swReset = regWr && regAddr == ADDR_CTRL && regWdata[CTRL_RESET_BIT];
    assign resetEv = swReset || (resetPin && !resetPinD_q);
    assign tripEv  = state_q == DFS_RUN && detCode != DFS_F_NONE;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resetPinD_q <= 1'b0;
        end else begin
            resetPinD_q <= resetPin;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DFS_RUN;
            code_q  <= DFS_F_NONE;
        end else begin
            unique case (state_q)
                DFS_RUN: begin
                    if (tripEv) begin
                        state_q <= DFS_TRIP;
                        code_q  <= detCode;
                    end
                end
                DFS_TRIP: begin
                    if (resetEv) begin
                        state_q <= DFS_RUN;
                        code_q  <= DFS_F_NONE;
                    end
                end
                default: begin
                    state_q <= DFS_TRIP;
                    code_q  <= DFS_F_NONE;
                end
            endcase
        end
    end

    // Gate block is combinational on the latch so a trip costs no extra edge.
    assign gateEnable = state_q == DFS_RUN && !tripEv && !cutoff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_fault_view   <= DFS_F_NONE;
            hardware_diag_fault <= 1'b0;
            drive_overload_trip <= 1'b0;
        end else begin
            active_fault_view   <= tripEv ? detCode :
                                   resetEv ? DFS_F_NONE : code_q;
            hardware_diag_fault <= tripEv ? detCode == DFS_F_HWD :
                                   resetEv ? 1'b0 : hardware_diag_fault;
            drive_overload_trip <= tripEv ? detCode == DFS_F_IOLT :
                                   resetEv ? 1'b0 : drive_overload_trip;
        end
    end

    // History: slot 0 is newest, the oldest falls off the end.
    dfs_hist_s hist_q [HIST_DEPTH];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                hist_q[i] <= '0;
            end
        end else if (tripEv) begin
            hist_q[0] <= '{code: detCode, status: opStatus};
            for (int i = 1; i < HIST_DEPTH; i++) begin
                hist_q[i] <= hist_q[i-1];
            end
        end
    end

    // Interrupts: set wins over write-one-to-clear.
    logic [IRQ_W-1:0] irqStat_q;
    logic [IRQ_W-1:0] irqMask_q;
    logic [IRQ_W-1:0] irqSet;
    logic             comRise;
    logic             comLost_q;

    assign comRise = sense.keypadLost && !comLost_q;
    assign irqSet  = {comRise, tripEv};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            comLost_q <= 1'b0;
            irqStat_q <= '0;
            irqMask_q <= '0;
        end else begin
            comLost_q <= sense.keypadLost;
            irqStat_q <= irqSet | (irqStat_q &
                ~((regWr && regAddr == ADDR_IRQ_STAT) ?
                  regWdata[IRQ_W-1:0] : '0));
            if (regWr && regAddr == ADDR_IRQ_MASK) begin
                irqMask_q <= regWdata[IRQ_W-1:0];
            end
        end
    end
    assign irqOut = |(irqStat_q & irqMask_q);

    // Register read: one cycle latency, unmapped reads zero.
    function automatic logic [31:0] histWord(input dfs_hist_s h);
        return {12'h000, h.code, h.status};
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else begin
            regRdata <= '0;
            if (regRd) begin
                if (regAddr == ADDR_ACTIVE) begin
                    regRdata <= {27'h0, cutoff, code_q};
                end else if (regAddr == ADDR_IRQ_STAT) begin
                    regRdata <= {30'h0, irqStat_q};
                end else if (regAddr == ADDR_IRQ_MASK) begin
                    regRdata <= {30'h0, irqMask_q};
                end else if (regAddr >= ADDR_HIST0 &&
                             regAddr < ADDR_HIST0 + 4'(HIST_DEPTH)) begin
                    regRdata <= histWord(hist_q[HIST_IDX_W'(regAddr - ADDR_HIST0)]);
                end
            end
        end
    end

    // Checks.
    AST_TRIP_BLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tripEv |-> !gateEnable ##1 state_q == DFS_TRIP)
        else $error("trip did not block output");
    AST_LATCHED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_TRIP && !resetEv |=> state_q == DFS_TRIP && !gateEnable)
        else $error("fault latch released without reset");
    AST_RESET_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_TRIP && resetEv |=> state_q == DFS_RUN)
        else $error("reset did not clear fault");
    AST_HIST_SHIFT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tripEv |=> hist_q[0].code == $past(detCode) &&
                   hist_q[1] == $past(hist_q[0]))
        else $error("history not shifted on trip");
    AST_CUTOFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cutoff |-> !gateEnable)
        else $error("cutoff did not block output");
    AST_CUTOFF_NOLATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cutoff && detCode == DFS_F_NONE && state_q == DFS_RUN
        |=> state_q == DFS_RUN)
        else $error("cutoff latched a fault");
    AST_OC1: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_RUN && sense.over200 && !sense.shortThrough
        |=> code_q == DFS_F_OC1)
        else $error("overcurrent not recorded");
    AST_VIEW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tripEv |=> active_fault_view == $past(detCode))
        else $error("fault view wrong");
    AST_HWD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_RUN && detCode == DFS_F_HWD |=> hardware_diag_fault)
        else $error("diag fault not flagged");

    // Every detector must hold the gate low on its own, whatever the latch.
    AST_GND_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.gndFault |-> !gateEnable)
        else $error("ground fault left output on");

    AST_OV_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.busOver |-> !gateEnable)
        else $error("bus overvoltage left output on");

    AST_OL_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.over120 |-> !gateEnable)
        else $error("current limit left output on");

    AST_OH_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.heatSinkHot |-> !gateEnable)
        else $error("overheat left output on");

    AST_ETH_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ethDone |-> !gateEnable)
        else $error("motor thermal left output on");

    AST_EXT_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.extTrip |-> !gateEnable)
        else $error("external trip left output on");

    AST_LV_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.busUnder |-> !gateEnable)
        else $error("undervoltage left output on");

    AST_OC2_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.shortThrough |-> !gateEnable)
        else $error("short left output on");

    AST_PHO_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.phaseOpen |-> !gateEnable)
        else $error("phase open left output on");

    AST_HWD_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hwErr |-> !gateEnable)
        else $error("control error left output on");

    AST_COM_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.keypadLost |-> !gateEnable)
        else $error("keypad loss left output on");

    AST_IOLT_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ol110Done || ol130Done |-> !gateEnable)
        else $error("drive overload left output on");

    AST_NTC_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sense.tempSenseOpen |-> !gateEnable)
        else $error("sensor open left output on");

    // Latch, flags and history bookkeeping.
    AST_OC2_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_RUN && sense.shortThrough |=> code_q == DFS_F_OC2)
        else $error("short not recorded");

    AST_IOLT_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_RUN && detCode == DFS_F_IOLT |=> drive_overload_trip)
        else $error("drive overload not flagged");

    AST_FIRST_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_TRIP && !resetEv |=> code_q == $past(code_q))
        else $error("latched code changed");

    AST_VIEW_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_TRIP && resetEv |=> active_fault_view == DFS_F_NONE)
        else $error("fault view kept after reset");

    AST_DIAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == DFS_TRIP && resetEv
        |=> !hardware_diag_fault && !drive_overload_trip)
        else $error("fault flags kept after reset");

    AST_HIST_TAIL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tripEv |=> hist_q[4] == $past(hist_q[3]))
        else $error("oldest history slot not displaced");

    AST_HIST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !tripEv |=> hist_q[0] == $past(hist_q[0]))
        else $error("history changed without a trip");

    AST_IRQ_COM: assert property (@(posedge clk_sys) disable iff (!rst_n)
        comRise |=> irqStat_q[IRQ_COM_BIT])
        else $error("keypad loss not flagged");

    AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !regRd |=> regRdata == '0)
        else $error("read data outside its cycle");

    // Covers for the main scenarios.
    COV_TRIP: cover property (@(posedge clk_sys) tripEv);
    COV_CLEAR: cover property (@(posedge clk_sys) state_q == DFS_TRIP && resetEv);
    COV_CUTOFF: cover property (@(posedge clk_sys) cutoff ##1 !cutoff);
    COV_PIN_RESET: cover property (@(posedge clk_sys)
        state_q == DFS_TRIP && resetPin && !resetPinD_q);
    COV_OVERLOAD: cover property (@(posedge clk_sys)
        tripEv && detCode == DFS_F_IOLT);
endmodule
`default_nettype wire

// [test/dfs_frontend_model.sv]
// Behavioural sensing front end and terminal block facing the supervisor.
// Assumes its controls change right after rising edges of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module dfs_frontend_model (
    input  wire logic                clk_sys,
    input  wire logic [16:0]         levelReq,
    input  wire logic                contactClosed,
    input  wire logic                resetPress,
    output var  dfs_pkg::dfs_sense_s senseOut,
    output logic                     fault_reset_terminal
);
    import dfs_pkg::*;
    logic [2:0] pressCnt_q = 3'h0;

    // A normally open contact reads active only while it is closed.
    always_comb begin
        senseOut = dfs_sense_s'(levelReq);
        senseOut.extTrip = levelReq[6] | contactClosed;
    end

    // A press lasts several clocks so the input synchroniser sees an edge.
    always_ff @(posedge clk_sys) begin
        if (resetPress)
            pressCnt_q <= 3'h4;
        else if (pressCnt_q != 3'h0)
            pressCnt_q <= pressCnt_q - 3'h1;
    end
    assign fault_reset_terminal = (pressCnt_q != 3'h0);
endmodule
`default_nettype wire

// [test/dfs_supervisor_tb_top.sv]
// Self-checking bench for the drive fault supervisor with a front end model.
// Assumes the short overload counts set below and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dfs_supervisor_tb_top;
    import dfs_pkg::*;
    localparam int MOTOR_CYC = 6;
    localparam int OL110_CYC = 16;
    localparam int OL130_CYC = 10;
    localparam logic [4:0] IMM_BIT [15] = '{16, 14, 12, 11, 10, 9, 8, 7,
                                             6, 5, 4, 3, 1, 2, 0};
    localparam logic [3:0] IMM_CODE [15] = '{4'h1, 4'h4, 4'h2, 4'h3, 4'h8,
        4'h5, 4'h9, 4'hA, 4'h7, 4'hB, 4'hB, 4'hB, 4'hB, 4'hE, 4'hC};
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic [16:0]       levelReq = 17'h0;
    logic              contactClosed = 1'b0;
    logic              resetPress = 1'b0;
    logic              instant_cutoff_input = 1'b0;
    logic [STAT_W-1:0] opStatus = 16'h0;
    logic [3:0]        regAddr = 4'h0;
    logic [31:0]       regWdata = 32'h0;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic              rdTaken = 1'b0;
    dfs_sense_s        senseIn;
    logic              fault_reset_terminal;
    logic [31:0]       regRdata;
    logic              gateEnable;
    logic [CODE_W-1:0] active_fault_view;
    logic              hardware_diag_fault;
    logic              drive_overload_trip;
    logic              irqOut;
    logic [31:0]       expQ [$];
    logic [19:0]       histQ [$];
    int                fail_count = 0;
    int                comparisons = 0;
    int                cycles = 0;

    dfs_frontend_model u_fe (.clk_sys(clk_sys), .levelReq(levelReq),
        .contactClosed(contactClosed), .resetPress(resetPress),
        .senseOut(senseIn), .fault_reset_terminal(fault_reset_terminal));

    dfs_supervisor #(.MotorOlCyc(MOTOR_CYC), .DrvOl110Cyc(OL110_CYC),
        .DrvOl130Cyc(OL130_CYC)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .senseIn(senseIn), .instant_cutoff_input(instant_cutoff_input),
        .fault_reset_terminal(fault_reset_terminal), .opStatus(opStatus),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .gateEnable(gateEnable),
        .active_fault_view(active_fault_view),
        .hardware_diag_fault(hardware_diag_fault),
        .drive_overload_trip(drive_overload_trip), .irqOut(irqOut));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    // Read data is judged by the monitor in the cycle after the strobe.
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk_sys);
        regRd <= 1'b0;
    endtask

    always @(posedge clk_sys) rdTaken <= regRd;

    always @(negedge clk_sys) begin
        if (rdTaken) begin
            if (expQ.size() == 0)
                chk(regRdata, 32'hDEAD_BEEF);
            else
                chk(regRdata, expQ.pop_front());
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic clear_fault(input logic viaTerminal);
        levelReq <= 17'h0;
        tick(4);
        @(negedge clk_sys);
        chk(gateEnable, 1'b0);
        tick(1);
        if (viaTerminal) begin
            resetPress <= 1'b1;
            tick(1);
            resetPress <= 1'b0;
            tick(6);
        end else begin
            reg_wr(ADDR_CTRL, 32'h1);
            tick(2);
        end
        @(negedge clk_sys);
        chk(gateEnable, 1'b1);
        tick(1);
    endtask

    // Raises the given levels, then checks gate, flags, view and newest history.
    task automatic trip(input logic [16:0] lv, input logic [3:0] code,
                        input int dly);
        logic [15:0] st;
        st = 16'($urandom());
        opStatus <= st;
        tick(1);
        levelReq <= lv;
        if (dly > 0) begin
            tick(dly - 2);
            @(negedge clk_sys);
            chk(gateEnable, 1'b1);
            tick(8);
        end else begin
            tick(2);
        end
        @(negedge clk_sys);
        chk(gateEnable, 1'b0);
        tick(1);
        @(negedge clk_sys);
        chk(active_fault_view, {28'h0, code});
        chk(hardware_diag_fault, code == 4'hB);
        chk(drive_overload_trip, code == 4'hD);
        reg_rd(ADDR_ACTIVE, {28'h0, code});
        reg_rd(ADDR_HIST0, {12'h0, code, st});
        histQ.push_front({code, st});
    endtask

    initial begin
        void'($urandom(32'h7ac5ba1c));
        tick(20);
        rst_n <= 1'b1;
        reg_rd(ADDR_ACTIVE, 32'h0);
        reg_wr(4'hF, 32'hFFFF_FFFF);
        reg_rd(4'hF, 32'h0);
        for (int i = 0; i < 15; i++) begin
            trip(17'h1 << IMM_BIT[i], IMM_CODE[i], 0);
            clear_fault(i == 3);
        end
        for (int k = 0; k < 5; k++)
            reg_rd(ADDR_HIST0 + 4'(k), {12'h0, histQ[k]});
        trip(17'h0_8000, 4'h6, MOTOR_CYC + 2);
        clear_fault(1'b0);
        trip(17'h0_2000, 4'hD, OL110_CYC + 2);
        clear_fault(1'b0);
        trip(17'h1_0000, 4'h1, 0);
        levelReq <= 17'h1_0100;
        tick(4);
        reg_rd(ADDR_ACTIVE, 32'h1);
        clear_fault(1'b0);
        trip(17'h1_0100, 4'h9, 0);
        levelReq <= 17'h0;
        contactClosed <= 1'b1;
        tick(4);
        reg_rd(ADDR_ACTIVE, 32'h9);
        contactClosed <= 1'b0;
        clear_fault(1'b1);
        instant_cutoff_input <= 1'b1;
        tick(2);
        @(negedge clk_sys);
        chk(gateEnable, 1'b0);
        reg_rd(ADDR_ACTIVE, 32'h10);
        instant_cutoff_input <= 1'b0;
        tick(3);
        @(negedge clk_sys);
        chk(gateEnable, 1'b1);
        reg_rd(ADDR_IRQ_STAT, 32'h3);
        chk(irqOut, 1'b0);
        reg_wr(ADDR_IRQ_MASK, 32'h1);
        tick(1);
        @(negedge clk_sys);
        chk(irqOut, 1'b1);
        reg_wr(ADDR_IRQ_STAT, 32'h1);
        tick(1);
        @(negedge clk_sys);
        chk(irqOut, 1'b0);
        reg_rd(ADDR_IRQ_STAT, 32'h2);
        reg_wr(ADDR_IRQ_STAT, 32'h2);
        reg_rd(ADDR_IRQ_STAT, 32'h0);
        tick(3);
        give_verdict();
    end
endmodule
`default_nettype wire
